// file: rtl/fhd_pkg.sv
// Shared constants and types for the floppy host data and rate register block.
// Functional notes
// R01 - Data byte port at 3F5, read and write.
// R02 - Host paces data accesses by request and direction.
// R03 - Every reset leaves the FIFO disabled.
// R04 - FIFO inactive at command start; single bytes.
// R05 - Execution start flushes all FIFO contents.
// R06 - Overrun or underrun ends command and transfer.
// R07 - Underrun on write pads with zero bytes.
// R08 - Host drains leftover bytes after read overrun.
// R09 - Host service latency within threshold budget.
// R10 - Input status register at 3F7, read only.
// R11 - Compat mode leaves bits 0-6 undriven.
// R12 - Bit 7 is inverted cable or forced value.
// R13 - Alt mode bit0 density, bits 1-2 rate.
// R14 - Alt mode bits 3-6 read one.
// R15 - Legacy mode bit3 DMA enable, 4-6 zero.
// R16 - Legacy mode bit2 precomp, bits 0-1 rate.
// R17 - Rate keeps soft reset, hard reset 250k.
// R18 - Rate control write only at 3F7.
// R19 - Legacy precomp bit stored, readable, survives soft reset.
// R20 - Density output high after hard reset and after 500k or 1M rate writes.
// R21 - Most recent rate write of either register wins.
// R22 - Direction one means read; request one allows.
// R23 - Stored mode picks the 3F7 layouts.
package fhd_pkg;

   // Host-side I/O addresses.
   localparam logic [9:0] FHD_ADDR_MSR     = 10'h3f4;
   localparam logic [9:0] FHD_ADDR_DATA    = 10'h3f5;
   localparam logic [9:0] FHD_ADDR_INP     = 10'h3f7;

   // Rate codes.
   localparam logic [1:0] FHD_RATE_500K    = 2'h0;
   localparam logic [1:0] FHD_RATE_300K    = 2'h1;
   localparam logic [1:0] FHD_RATE_250K    = 2'h2;
   localparam logic [1:0] FHD_RATE_1M      = 2'h3;

   // Interface modes for the 3F7 layouts.
   localparam logic [1:0] FHD_MODE_COMPAT  = 2'h0;
   localparam logic [1:0] FHD_MODE_ALT     = 2'h1;
   localparam logic [1:0] FHD_MODE_LEGACY  = 2'h2;

   // Field positions.
   localparam int         FHD_MSR_REQ_BIT  = 7;
   localparam int         FHD_MSR_XFD_BIT  = 6;
   localparam int         FHD_DSR_SWRST_BIT = 7;
   localparam int         FHD_RTC_NOCOMP_BIT = 2;

   // Values after reset.
   localparam logic [1:0] FHD_RATE_RST     = FHD_RATE_250K;
   localparam logic       FHD_DENS_RST     = 1'b1;
   localparam logic       FHD_FIFO_EN_RST  = 1'b0;
   localparam logic [7:0] FHD_OE_B_RST     = 8'hff;

   // FIFO geometry.
   localparam logic [4:0] FHD_FIFO_DEPTH   = 5'h10;
   localparam logic [4:0] FHD_BYTE_DEPTH   = 5'h01;

   // Host service budget margin.
   localparam int         FHD_CLK_NS       = 40;
   localparam int         FHD_SVC_MARGIN_NS = 1500;
   localparam int         FHD_SVC_MARGIN_CYC = (FHD_SVC_MARGIN_NS + FHD_CLK_NS - 1) / FHD_CLK_NS;

   // Host command port offsets.
   localparam logic [2:0] FHD_H_TXD        = 3'h0;
   localparam logic [2:0] FHD_H_RXGO       = 3'h1;
   localparam logic [2:0] FHD_H_RXD        = 3'h2;
   localparam logic [2:0] FHD_H_STAT       = 3'h3;
   localparam logic [2:0] FHD_H_RTC        = 3'h4;
   localparam logic [2:0] FHD_H_DIRGO      = 3'h5;
   localparam logic [2:0] FHD_H_DIRV       = 3'h6;
   localparam logic [2:0] FHD_H_DSR        = 3'h7;

   // Host operation codes.
   localparam logic [2:0] FHD_OP_DOUT      = 3'h0;
   localparam logic [2:0] FHD_OP_DIN       = 3'h1;
   localparam logic [2:0] FHD_OP_RTC       = 3'h2;
   localparam logic [2:0] FHD_OP_INP       = 3'h3;
   localparam logic [2:0] FHD_OP_DSR       = 3'h4;

   typedef enum logic [2:0] {
      FHD_H_IDLE, FHD_H_POLL, FHD_H_PW1, FHD_H_PW2, FHD_H_XFER, FHD_H_XW1, FHD_H_XW2
   } fhd_hst_state_t;

endpackage : fhd_pkg

// file: rtl/fhd_bus_if.sv
// Host I/O bus between the host end and the floppy register end.
`timescale 1ns/1ps
interface fhd_bus_if (
   input wire logic sys_clk
);
   logic [9:0] addr;
   logic       wr;
   logic       rd;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [7:0] rdata_oe_b;
   logic [7:0] dbus;

   // Undriven data lines float high through the bus pull-ups.
   assign dbus = rdata | rdata_oe_b;

   modport dev (input addr, input wr, input rd, input wdata, output rdata, output rdata_oe_b);
   modport host (output addr, output wr, output rd, output wdata, input dbus);
endinterface : fhd_bus_if

// file: rtl/fhd_dev.sv
// Floppy data port FIFO, input status and rate control registers.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module fhd_dev (
   // Clock, reset and enable
   input  wire logic            sys_clk,
   input  wire logic            rst_b,
   input  wire logic            ce,
   // Host bus
   fhd_bus_if.dev               bus,
   // Command engine side
   input  wire logic            core_cmd_start,
   input  wire logic            core_exec_start,
   input  wire logic            core_exec_end,
   input  wire logic            core_to_host,
   input  wire logic            core_busy,
   input  wire logic            core_push,
   input  wire logic [7:0]      core_push_data,
   input  wire logic            core_pop,
   input  wire logic            core_cfg_wr,
   input  wire logic            core_cfg_fifo_en,
   input  wire logic [3:0]      core_cfg_thresh,
   output logic [7:0]           core_pop_data,
   output logic                 core_fifo_empty,
   output logic                 core_fifo_req,
   output logic                 core_abort,
   output logic                 core_zero_pad,
   // Configuration and cable
   input  wire logic [1:0]      cfg_mode,
   input  wire logic            force_chg_en,
   input  wire logic            force_chg_val,
   input  wire logic            dma_request_enable,
   input  wire logic            media_changed_pin_b,
   // Drive and controller outputs
   output logic [1:0]           rate_code,
   output logic                 precomp_disable,
   output logic                 density_select_out,
   output logic                 soft_reset_pulse,
   output logic                 host_request_flag,
   output logic                 transfer_direction_flag
);
   import fhd_pkg::*;

   typedef struct packed {
      logic [15:0][7:0] mem;
      logic [3:0]       wp;
      logic [3:0]       rp;
      logic [4:0]       cnt;
      logic             fifo_en;
      logic [3:0]       thr;
      logic             exec;
      logic             pad;
      logic [1:0]       rate;
      logic             nocomp;
      logic             dens;
      logic [2:0]       pin_s;
      logic             pin_f;
      logic [7:0]       rdata;
      logic [7:0]       oe_b;
      logic [7:0]       head;
      logic             hrq;
      logic             xfd;
      logic             empty;
      logic             req;
      logic             abort;
      logic             swrst;
   } fhd_dev_st_t;

   fhd_dev_st_t s_r;
   fhd_dev_st_t s_nxt;

   function automatic logic dens_of(input logic [1:0] r);
      dens_of = (r == FHD_RATE_500K) || (r == FHD_RATE_1M);
   endfunction : dens_of

   always_comb begin
      logic       push;
      logic       pop;
      logic [7:0] pdata;
      logic [4:0] cap;
      logic [4:0] ncap;
      logic       hwr_data;
      logic       hrd_data;
      logic       chg;
      logic       nhigh;
      s_nxt    = s_r;
      push     = 1'b0;
      pop      = 1'b0;
      pdata    = 8'h00;
      ncap     = 5'h00;
      cap      = (s_r.fifo_en && s_r.exec) ? FHD_FIFO_DEPTH : FHD_BYTE_DEPTH; // R04
      hwr_data = bus.wr && (bus.addr == FHD_ADDR_DATA);
      hrd_data = bus.rd && (bus.addr == FHD_ADDR_DATA);
      chg      = force_chg_en ? force_chg_val : ~s_r.pin_f; // R12
      nhigh    = (s_r.rate == FHD_RATE_250K) || (s_r.rate == FHD_RATE_300K);
      s_nxt.abort = 1'b0;
      s_nxt.swrst = 1'b0;
      s_nxt.oe_b  = FHD_OE_B_RST;
      s_nxt.rdata = 8'h00;

      // Three-stage cable synchroniser; a change counts once stages two and three agree.
      s_nxt.pin_s = {s_r.pin_s[1:0], media_changed_pin_b};
      if (s_r.pin_s[1] == s_r.pin_s[2]) begin
         s_nxt.pin_f = s_r.pin_s[2];
      end

      if (core_cmd_start) begin
         s_nxt.exec = 1'b0; // R04
         s_nxt.pad  = 1'b0;
      end
      if (core_exec_end) begin
         s_nxt.exec = 1'b0;
         s_nxt.pad  = 1'b0;
      end
      if (core_cfg_wr) begin
         s_nxt.fifo_en = core_cfg_fifo_en; // R03
         s_nxt.thr     = core_cfg_thresh;
      end

      if (core_exec_start) begin
         // Flush wins over any transfer in the same cycle so no stale byte survives.
         s_nxt.cnt  = 5'h00; // R05
         s_nxt.wp   = 4'h0;
         s_nxt.rp   = 4'h0;
         s_nxt.exec = 1'b1;
         s_nxt.pad  = 1'b0;
      end else begin
         // Host side of the data port.
         if (hwr_data && !core_to_host && (s_r.cnt < cap)) begin // R01
            push  = 1'b1;
            pdata = bus.wdata;
         end
         if (hrd_data && core_to_host && (s_r.cnt != 5'h00)) begin // R01
            pop           = 1'b1;
            s_nxt.rdata   = s_r.head;
            s_nxt.oe_b    = 8'h00;
         end else if (hrd_data) begin
            s_nxt.rdata   = s_r.head;
            s_nxt.oe_b    = 8'h00;
         end
         // Disk side of the data port.
         if (core_push && core_to_host) begin
            if (s_r.cnt < cap) begin
               push  = 1'b1;
               pdata = core_push_data;
            end else if (s_r.exec) begin
               // Leftover bytes stay for the host to drain before results.
               s_nxt.abort = 1'b1; // R06
               s_nxt.exec  = 1'b0; // R08
            end
         end
         if (core_pop && !core_to_host) begin
            if (s_r.cnt != 5'h00) begin
               pop = 1'b1;
            end else if (s_r.exec) begin
               s_nxt.abort = 1'b1; // R06
               s_nxt.exec  = 1'b0;
               s_nxt.pad   = 1'b1; // R07
            end
         end
      end

      if (push) begin
         s_nxt.mem[s_r.wp] = pdata;
         s_nxt.wp          = s_r.wp + 4'h1;
      end
      if (pop) begin
         s_nxt.rp = s_r.rp + 4'h1;
      end
      if (!core_exec_start) begin
         s_nxt.cnt = s_r.cnt + {4'h0, push} - {4'h0, pop};
      end

      // Rate and status register writes.
      if (bus.wr && (bus.addr == FHD_ADDR_MSR)) begin
         s_nxt.rate = bus.wdata[1:0]; // R21
         s_nxt.dens = dens_of(bus.wdata[1:0]);
         if (bus.wdata[FHD_DSR_SWRST_BIT]) begin
            // Soft reset spares the rate, precomp and density settings.
            s_nxt.fifo_en = FHD_FIFO_EN_RST; // R03
            s_nxt.thr     = 4'h0;
            s_nxt.cnt     = 5'h00;
            s_nxt.wp      = 4'h0;
            s_nxt.rp      = 4'h0;
            s_nxt.exec    = 1'b0;
            s_nxt.pad     = 1'b0;
            s_nxt.swrst   = 1'b1; // R17
         end
      end
      if (bus.wr && (bus.addr == FHD_ADDR_INP)) begin
         s_nxt.rate = bus.wdata[1:0]; // R18
         s_nxt.dens = dens_of(bus.wdata[1:0]); // R20
         if (cfg_mode == FHD_MODE_LEGACY) begin
            s_nxt.nocomp = bus.wdata[FHD_RTC_NOCOMP_BIT]; // R19
         end
      end

      // Register reads other than the data port.
      if (bus.rd && (bus.addr == FHD_ADDR_MSR)) begin
         s_nxt.rdata = {s_r.hrq, s_r.xfd, 1'b0, core_busy, 4'h0}; // R22
         s_nxt.oe_b  = 8'h00;
      end
      if (bus.rd && (bus.addr == FHD_ADDR_INP)) begin // R10
         case (cfg_mode) // R23
            FHD_MODE_COMPAT: begin
               s_nxt.rdata = {chg, 7'h00};
               s_nxt.oe_b  = 8'h7f; // R11
            end
            FHD_MODE_ALT: begin
               s_nxt.rdata = {chg, 4'hf, s_r.rate, nhigh}; // R13 R14
               s_nxt.oe_b  = 8'h00;
            end
            FHD_MODE_LEGACY: begin
               s_nxt.rdata = {chg, 3'h0, dma_request_enable, s_r.nocomp, s_r.rate}; // R15 R16
               s_nxt.oe_b  = 8'h00;
            end
            default: begin
               s_nxt.rdata = {chg, 7'h00};
               s_nxt.oe_b  = 8'h7f;
            end
         endcase
      end

      // Registered views of the new FIFO state.
      ncap        = (s_nxt.fifo_en && s_nxt.exec) ? FHD_FIFO_DEPTH : FHD_BYTE_DEPTH;
      s_nxt.empty = (s_nxt.cnt == 5'h00);
      s_nxt.head  = (s_nxt.pad || s_nxt.empty) ? 8'h00 : s_nxt.mem[s_nxt.rp]; // R07
      s_nxt.xfd   = core_to_host; // R22
      s_nxt.hrq   = core_to_host ? !s_nxt.empty : (s_nxt.cnt < ncap); // R02
      if (core_to_host) begin
         s_nxt.req = s_nxt.exec && s_nxt.fifo_en && (s_nxt.cnt > {1'b0, s_nxt.thr});
      end else begin
         s_nxt.req = s_nxt.exec && s_nxt.fifo_en && ((FHD_FIFO_DEPTH - s_nxt.cnt) > {1'b0, s_nxt.thr});
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         s_r         <= '0;
         s_r.rate    <= FHD_RATE_RST; // R17
         s_r.dens    <= FHD_DENS_RST; // R20
         s_r.fifo_en <= FHD_FIFO_EN_RST;
         s_r.oe_b    <= FHD_OE_B_RST;
         s_r.empty   <= 1'b1;
         s_r.hrq     <= 1'b1;
         s_r.pin_s   <= 3'h7;
         s_r.pin_f   <= 1'b1;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign bus.rdata               = s_r.rdata;
   assign bus.rdata_oe_b          = s_r.oe_b;
   assign core_pop_data           = s_r.head;
   assign core_fifo_empty         = s_r.empty;
   assign core_fifo_req           = s_r.req;
   assign core_abort              = s_r.abort;
   assign core_zero_pad           = s_r.pad;
   assign rate_code               = s_r.rate;
   assign precomp_disable         = s_r.nocomp;
   assign density_select_out      = s_r.dens;
   assign soft_reset_pulse        = s_r.swrst;
   assign host_request_flag       = s_r.hrq;
   assign transfer_direction_flag = s_r.xfd;

endmodule : fhd_dev

// file: rtl/fhd_host.sv
// Host end: polls the status flags and moves bytes through the floppy registers.
`timescale 1ns/1ps
module fhd_host (
   // Clock, reset and enable
   input  wire logic            sys_clk,
   input  wire logic            rst_b,
   input  wire logic            ce,
   // Host bus
   fhd_bus_if.host              bus,
   // Software command port
   input  wire logic [2:0]      usr_addr,
   input  wire logic [7:0]      usr_wdata,
   input  wire logic            usr_wr,
   input  wire logic            usr_rd,
   output logic [7:0]           usr_rdata
);
   import fhd_pkg::*;

   typedef struct packed {
      fhd_hst_state_t st;
      logic [2:0]     op;
      logic [7:0]     txd;
      logic [7:0]     rxd;
      logic [7:0]     dirv;
      logic           rx_valid;
      logic [9:0]     addr;
      logic           wr;
      logic           rd;
      logic [7:0]     wdata;
      logic [7:0]     urdata;
   } fhd_host_st_t;

   fhd_host_st_t s_r;
   fhd_host_st_t s_nxt;

   always_comb begin
      logic want_dio;
      logic busy;
      s_nxt        = s_r;
      s_nxt.wr     = 1'b0;
      s_nxt.rd     = 1'b0;
      s_nxt.urdata = 8'h00;
      want_dio     = (s_r.op == FHD_OP_DIN);
      busy         = (s_r.st != FHD_H_IDLE);

      // Software reads; a new receive wins over the clear by the read.
      if (usr_rd) begin
         case (usr_addr)
            FHD_H_RXD: begin
               s_nxt.urdata   = s_r.rxd;
               s_nxt.rx_valid = 1'b0;
            end
            FHD_H_STAT: s_nxt.urdata = {6'h00, busy, s_r.rx_valid};
            FHD_H_DIRV: s_nxt.urdata = s_r.dirv;
            default:    s_nxt.urdata = 8'h00;
         endcase
      end
      // Commands while busy are ignored.
      if (usr_wr && !busy) begin
         s_nxt.txd = usr_wdata;
         case (usr_addr)
            FHD_H_TXD: begin
               s_nxt.op = FHD_OP_DOUT;
               s_nxt.st = FHD_H_POLL;
            end
            FHD_H_RXGO: begin
               s_nxt.op = FHD_OP_DIN;
               s_nxt.st = FHD_H_POLL;
            end
            FHD_H_RTC: begin
               s_nxt.op = FHD_OP_RTC;
               s_nxt.st = FHD_H_XFER;
            end
            FHD_H_DIRGO: begin
               s_nxt.op = FHD_OP_INP;
               s_nxt.st = FHD_H_XFER;
            end
            FHD_H_DSR: begin
               s_nxt.op = FHD_OP_DSR;
               s_nxt.st = FHD_H_XFER;
            end
            default: s_nxt.st = s_r.st;
         endcase
      end

      case (s_r.st)
         FHD_H_IDLE: s_nxt.st = s_nxt.st;
         FHD_H_POLL: begin
            s_nxt.rd   = 1'b1;
            s_nxt.addr = FHD_ADDR_MSR;
            s_nxt.st   = FHD_H_PW1;
         end
         FHD_H_PW1: s_nxt.st = FHD_H_PW2;
         FHD_H_PW2: begin
            // Each byte waits for request set and the matching direction.
            if (bus.dbus[FHD_MSR_REQ_BIT] && (bus.dbus[FHD_MSR_XFD_BIT] == want_dio)) begin // R02 R09
               s_nxt.st = FHD_H_XFER;
            end else begin
               s_nxt.st = FHD_H_POLL; // R04
            end
         end
         FHD_H_XFER: begin
            s_nxt.wdata = s_r.txd;
            case (s_r.op)
               FHD_OP_DOUT: begin
                  s_nxt.wr   = 1'b1;
                  s_nxt.addr = FHD_ADDR_DATA;
               end
               FHD_OP_DIN: begin
                  s_nxt.rd   = 1'b1;
                  s_nxt.addr = FHD_ADDR_DATA; // R08
               end
               FHD_OP_RTC: begin
                  s_nxt.wr    = 1'b1;
                  s_nxt.addr  = FHD_ADDR_INP;
                  s_nxt.wdata = {6'h00, s_r.txd[1:0]} | {5'h00, s_r.txd[2], 2'h0}; // R18
               end
               FHD_OP_INP: begin
                  s_nxt.rd   = 1'b1;
                  s_nxt.addr = FHD_ADDR_INP;
               end
               default: begin
                  s_nxt.wr   = 1'b1;
                  s_nxt.addr = FHD_ADDR_MSR;
               end
            endcase
            s_nxt.st = (s_r.op == FHD_OP_DIN || s_r.op == FHD_OP_INP) ? FHD_H_XW1 : FHD_H_IDLE;
         end
         FHD_H_XW1: s_nxt.st = FHD_H_XW2;
         FHD_H_XW2: begin
            if (s_r.op == FHD_OP_DIN) begin
               s_nxt.rxd      = bus.dbus;
               s_nxt.rx_valid = 1'b1;
            end else begin
               s_nxt.dirv = bus.dbus;
            end
            s_nxt.st = FHD_H_IDLE;
         end
         default: s_nxt.st = FHD_H_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         s_r    <= '0;
         s_r.st <= FHD_H_IDLE;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign bus.addr  = s_r.addr;
   assign bus.wr    = s_r.wr;
   assign bus.rd    = s_r.rd;
   assign bus.wdata = s_r.wdata;
   assign usr_rdata = s_r.urdata;

endmodule : fhd_host

// file: verif/fhd_props.sv
// Bus checker for the floppy host register interface.
`timescale 1ns/1ps
module fhd_props (
   // Clock and reset
   input wire logic       sys_clk,
   input wire logic       rst_b,
   // Host bus
   input wire logic [9:0] addr,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic [7:0] rdata_oe_b,
   input wire logic [7:0] dbus
);
   import fhd_pkg::*;
   logic msr_rd;
   logic data_acc;
   logic mapped;
   assign msr_rd   = rd && (addr == FHD_ADDR_MSR);
   assign data_acc = (wr || rd) && (addr == FHD_ADDR_DATA);
   assign mapped   = (addr == FHD_ADDR_MSR) || (addr == FHD_ADDR_DATA) || (addr == FHD_ADDR_INP);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   // The answer lands one cycle after the strobe and only there.
   sequence drives_all;
      ##1 rdata_oe_b == 8'h00;
   endsequence
   strobe_excl_a: assert property (!(wr && rd))
      else $error("read and write strobes together");
   strobe_pulse_a: assert property ((wr || rd) |=> !(wr || rd))
      else $error("bus strobe longer than one cycle");
   idle_release_a: assert property (!$past(rd) |-> rdata_oe_b == 8'hff && dbus == 8'hff)
      else $error("bus driven without a read");
   unmapped_quiet_a: assert property (rd && !mapped |=> rdata_oe_b == 8'hff)
      else $error("unmapped read drove the bus");
   data_answer_a: assert property (rd && addr == FHD_ADDR_DATA |-> drives_all)
      else $error("data port read not answered");
   msr_layout_a: assert property (msr_rd |-> drives_all ##0 (rdata[5] == 1'b0 && rdata[3:0] == 4'h0))
      else $error("status read layout wrong");
   input_answer_a: assert property (rd && addr == FHD_ADDR_INP |=> !rdata_oe_b[7] &&
      (rdata_oe_b[6:0] == 7'h7f || rdata_oe_b[6:0] == 7'h00)) else $error("input status drive pattern wrong");
   poll_first_a: assert property (data_acc |-> $past(msr_rd, 3))
      else $error("data access without a status poll");
   rate_reserved_a: assert property (wr && addr == FHD_ADDR_INP |-> wdata[7:3] == 5'h00)
      else $error("reserved rate control bits written nonzero");
endmodule : fhd_props

// file: verif/testbench.sv
// Self-checking bench joining the host end and the register end.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
   $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module testbench;
   import fhd_pkg::*;
   // Clock, reset and bench state
   logic       sys_clk;
   logic       rst_b = 1'b0;
   int         mismatches = 0, n_tests = 0, cycles = 0;
   logic [7:0] v;
   logic       seen;
   // Engine side
   logic       core_cmd_start = 1'b0, core_exec_start = 1'b0, core_to_host = 1'b0;
   logic       core_push = 1'b0, core_pop = 1'b0, core_cfg_wr = 1'b0, core_cfg_fifo_en = 1'b0;
   logic [7:0] core_push_data = 8'h00;
   logic [3:0] core_cfg_thresh = 4'h0;
   logic [7:0] core_pop_data;
   logic       core_fifo_empty, core_fifo_req, core_abort, core_zero_pad;
   // Configuration, cable and drive
   logic [1:0] cfg_mode = FHD_MODE_ALT;
   logic       force_chg_en = 1'b0, force_chg_val = 1'b0, dma_request_enable = 1'b0, media_changed_pin_b = 1'b1;
   logic [1:0] rate_code;
   logic       precomp_disable, density_select_out, soft_reset_pulse, host_request_flag, transfer_direction_flag;
   // Software port
   logic [2:0] usr_addr = 3'h0;
   logic [7:0] usr_wdata = 8'h00;
   logic       usr_wr = 1'b0, usr_rd = 1'b0;
   logic [7:0] usr_rdata;

   fhd_bus_if u_fhd_bus_if (.sys_clk(sys_clk));
   fhd_dev u_fhd_dev (.sys_clk(sys_clk), .rst_b(rst_b), .ce(1'b1), .bus(u_fhd_bus_if),
      .core_cmd_start(core_cmd_start), .core_exec_start(core_exec_start), .core_exec_end(1'b0),
      .core_to_host(core_to_host), .core_busy(1'b0), .core_push(core_push), .core_push_data(core_push_data),
      .core_pop(core_pop), .core_cfg_wr(core_cfg_wr), .core_cfg_fifo_en(core_cfg_fifo_en),
      .core_cfg_thresh(core_cfg_thresh), .core_pop_data(core_pop_data), .core_fifo_empty(core_fifo_empty),
      .core_fifo_req(core_fifo_req), .core_abort(core_abort), .core_zero_pad(core_zero_pad),
      .cfg_mode(cfg_mode), .force_chg_en(force_chg_en), .force_chg_val(force_chg_val),
      .dma_request_enable(dma_request_enable), .media_changed_pin_b(media_changed_pin_b),
      .rate_code(rate_code), .precomp_disable(precomp_disable), .density_select_out(density_select_out),
      .soft_reset_pulse(soft_reset_pulse), .host_request_flag(host_request_flag),
      .transfer_direction_flag(transfer_direction_flag));
   fhd_host u_fhd_host (.sys_clk(sys_clk), .rst_b(rst_b), .ce(1'b1), .bus(u_fhd_bus_if), .usr_addr(usr_addr),
      .usr_wdata(usr_wdata), .usr_wr(usr_wr), .usr_rd(usr_rd), .usr_rdata(usr_rdata));
   fhd_props u_fhd_props (.sys_clk(sys_clk), .rst_b(rst_b), .addr(u_fhd_bus_if.addr), .wr(u_fhd_bus_if.wr),
      .rd(u_fhd_bus_if.rd), .wdata(u_fhd_bus_if.wdata), .rdata(u_fhd_bus_if.rdata),
      .rdata_oe_b(u_fhd_bus_if.rdata_oe_b), .dbus(u_fhd_bus_if.dbus));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic give_verdict();
      if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict

   // The whole sequence needs well under a thousand cycles; a hung poll ends here.
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         mismatches++;
         give_verdict();
      end
   end

   task automatic hw_reset();
      @(posedge sys_clk) rst_b <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'b1;
   endtask : hw_reset

   task automatic uw(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      usr_addr  <= a;
      usr_wdata <= d;
      usr_wr    <= 1'b1;
      @(posedge sys_clk) usr_wr <= 1'b0;
   endtask : uw

   task automatic ur(input logic [2:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      usr_addr <= a;
      usr_rd   <= 1'b1;
      @(posedge sys_clk) usr_rd <= 1'b0;
      #1 d = usr_rdata;
   endtask : ur

   // Orders one host operation and polls the busy flag until it is done.
   task automatic op(input logic [2:0] a, input logic [7:0] d);
      logic [7:0] s;
      int         n;
      uw(a, d);
      s = 8'h02;
      n = 0;
      while (s[1] !== 1'b0 && n < 200) begin
         ur(FHD_H_STAT, s);
         n++;
      end
      if (s[1] !== 1'b0) mismatches++;
   endtask : op

   task automatic get(input logic [2:0] go, input logic [2:0] res, output logic [7:0] d);
      op(go, 8'h00);
      ur(res, d);
   endtask : get

   initial begin
      hw_reset();
      get(FHD_H_DIRGO, FHD_H_DIRV, v);
      `CHK(v, 8'h7d)
      `CHK({rate_code, density_select_out, precomp_disable}, 4'b1010)
      for (int c = 0; c < 4; c++) begin
         op(FHD_H_RTC, 8'(c));
         get(FHD_H_DIRGO, FHD_H_DIRV, v);
         `CHK(v, {5'h0f, 2'(c), 1'(c == 1 || c == 2)})
         `CHK(density_select_out, 1'(c == 0 || c == 3))
      end
      op(FHD_H_DSR, 8'h01);
      `CHK({soft_reset_pulse, rate_code}, {1'b0, FHD_RATE_300K})
      op(FHD_H_RTC, 8'h03);
      `CHK(rate_code, FHD_RATE_1M)
      @(posedge sys_clk) cfg_mode <= FHD_MODE_LEGACY;
      dma_request_enable <= 1'b1;
      op(FHD_H_RTC, 8'h05);
      get(FHD_H_DIRGO, FHD_H_DIRV, v);
      `CHK(v, 8'h0d)
      // A soft reset must keep precompensation and density even with bit 2 clear here.
      op(FHD_H_DSR, 8'h81);
      `CHK(soft_reset_pulse, 1'b1)
      @(posedge sys_clk) dma_request_enable <= 1'b0;
      get(FHD_H_DIRGO, FHD_H_DIRV, v);
      `CHK(v, 8'h05)
      `CHK({precomp_disable, density_select_out}, 2'b10)
      @(posedge sys_clk) cfg_mode <= FHD_MODE_COMPAT;
      get(FHD_H_DIRGO, FHD_H_DIRV, v);
      `CHK(v, 8'h7f)
      @(posedge sys_clk) media_changed_pin_b <= 1'b0;
      repeat (4) @(posedge sys_clk);
      get(FHD_H_DIRGO, FHD_H_DIRV, v);
      `CHK(v, 8'hff)
      @(posedge sys_clk) force_chg_en <= 1'b1;
      get(FHD_H_DIRGO, FHD_H_DIRV, v);
      `CHK(v, 8'h7f)
      @(posedge sys_clk) force_chg_val <= 1'b1;
      media_changed_pin_b <= 1'b1;
      get(FHD_H_DIRGO, FHD_H_DIRV, v);
      `CHK(v, 8'hff)
      @(posedge sys_clk) force_chg_en <= 1'b0;
      op(FHD_H_TXD, 8'ha5);
      `CHK({host_request_flag, core_fifo_empty, core_pop_data}, {2'b00, 8'ha5})
      @(posedge sys_clk) core_pop <= 1'b1;
      @(posedge sys_clk) core_pop <= 1'b0;
      op(FHD_H_TXD, 8'h5a);
      @(posedge sys_clk) core_exec_start <= 1'b1;
      @(posedge sys_clk) core_exec_start <= 1'b0;
      #1 `CHK(core_fifo_empty, 1'b1)
      @(posedge sys_clk) core_pop <= 1'b1;
      @(posedge sys_clk) core_pop <= 1'b0;
      #1 seen = core_abort;
      repeat (2) @(posedge sys_clk) #1 seen |= core_abort;
      `CHK({seen, core_zero_pad, core_pop_data}, {2'b11, 8'h00})
      @(posedge sys_clk) core_cmd_start <= 1'b1;
      @(posedge sys_clk) core_cmd_start <= 1'b0;
      #1 `CHK(core_zero_pad, 1'b0)
      @(posedge sys_clk) core_to_host <= 1'b1;
      core_cfg_fifo_en <= 1'b1;
      core_cfg_thresh <= 4'h8;
      core_cfg_wr <= 1'b1;
      @(posedge sys_clk) core_cfg_wr <= 1'b0;
      core_exec_start <= 1'b1;
      @(posedge sys_clk) core_exec_start <= 1'b0;
      seen = 1'b0;
      // Seventeen pushes against a sixteen byte store force an overrun.
      for (int i = 0; i < 17; i++) begin
         @(posedge sys_clk) core_push <= 1'b1;
         core_push_data <= 8'h40 + 8'(i);
         #1 seen |= core_abort;
         `CHK(core_fifo_req, 1'(i > 8))
      end
      @(posedge sys_clk) core_push <= 1'b0;
      #1 seen |= core_abort;
      @(posedge sys_clk) #1 seen |= core_abort;
      `CHK({seen, host_request_flag, transfer_direction_flag}, 3'b111)
      for (int i = 0; i < 16; i++) begin
         get(FHD_H_RXGO, FHD_H_RXD, v);
         `CHK(v, 8'h40 + 8'(i))
      end
      `CHK(core_fifo_empty, 1'b1)
      hw_reset();
      #1 `CHK({rate_code, density_select_out, precomp_disable}, 4'b1010)
      give_verdict();
   end
endmodule : testbench
